// *** rtl/sdf_pkg.sv ***
// constants, widths and shared helpers of the sinc3 decimation filter
package sdf_pkg;

	// ------------------------------------------------------------
	// clock and rate figures
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000; // master clock, 100 ns period
	localparam int MOD_DIV = 512; // master clocks per modulator sample
	localparam int SAMP_DIV = 256; // master clocks per input sample at gain 1
	localparam int SAMP_MULT_MAX = 8; // input sample multiplier for gains 8 to 128
	localparam int MOD_RATE_HZ = CLK_HZ / MOD_DIV; // 19.5 kHz modulator rate

	// ------------------------------------------------------------
	// notch select and settling
	// ------------------------------------------------------------
	localparam int CODE_W = 12; // width of the notch select field
	localparam int DCNT_W = 11; // width of the decimation counter
	localparam logic [CODE_W-1:0] CODE_MIN = 12'h013; // 19 -> first notch 1.028 kHz
	localparam logic [CODE_W-1:0] CODE_MAX = 12'h7d0; // 2000 -> first notch 9.76 Hz
	localparam logic [CODE_W-1:0] CODE_RST = 12'h7d0; // notch after reset
	localparam int SETTLE_PERIODS = 4; // output periods to settle after a step
	localparam logic [2:0] SETTLE_DONE = 3'h3; // words counted before a word is settled

	// ------------------------------------------------------------
	// datapath and buffering
	// ------------------------------------------------------------
	localparam int ACC_W = 34; // holds 2000^3 with more than 5 % headroom
	localparam int GAIN_W = 3; // gain select, 0..7 gives gain 1..128
	localparam int FIFO_DEPTH = 8; // words buffered between filter and output register
	localparam logic [8:0] MDIV_RST = 9'h1ff; // modulator divider after reset
	localparam logic [7:0] SDIV_RST = 8'hff; // input sample divider after reset

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// limit the notch select field to its legal span
	function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] c);
		if (c < CODE_MIN) begin
			return CODE_MIN;
		end else if (c > CODE_MAX) begin
			return CODE_MAX;
		end
		return c;
	endfunction

	// master clocks per input sample: 256 / min(gain, 8)
	function automatic logic [8:0] samp_period(input logic [GAIN_W-1:0] g);
		logic [GAIN_W-1:0] s;
		s = (g > 3'h3) ? 3'h3 : g;
		return 9'(SAMP_DIV >> s);
	endfunction

	// full scale of the sinc3 sum, decimation ratio cubed
	function automatic logic [ACC_W-1:0] cube(input logic [CODE_W-1:0] c);
		logic [ACC_W-1:0] w;
		w = ACC_W'(c);
		return ACC_W'(w * w * w);
	endfunction

endpackage

// *** rtl/sdf_stream_if.sv ***
// valid/ready word stream between the filter and its buffer
interface sdf_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// *** rtl/sdf_fifo.sv ***
// word buffer with valid and ready on both sides
module sdf_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// streams
	sdf_stream_if.snk s_in,
	sdf_stream_if.src s_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sdf_fifo_st_t;

	sdf_fifo_st_t st_q, st_d;
	logic push, pop;

	// ------------------------------------------------------------
	// handshake
	// ------------------------------------------------------------
	assign s_in.ready = (st_q.cnt != FULL);
	assign s_out.valid = (st_q.cnt != '0);
	assign s_out.data = st_q.mem[st_q.rp];
	assign push = s_in.valid & s_in.ready;
	assign pop = s_out.valid & s_out.ready;

	// next state: write, read and count
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wp] = s_in.data;
			st_d.wp = (st_q.wp == LAST) ? '0 : st_q.wp + 1'b1;
		end
		if (pop) begin
			st_d.rp = (st_q.rp == LAST) ? '0 : st_q.rp + 1'b1;
		end
		if (push && !pop) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (pop && !push) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// *** rtl/sdf_filter.sv ***
// sigma-delta rate generation and sinc3 decimation filter
module sdf_filter
	import sdf_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// modulator bitstream
	input wire logic i_mod_bit,
	// configuration
	input wire logic [GAIN_W-1:0] i_gain_sel,
	input wire logic [CODE_W-1:0] i_notch_select_field,
	input wire logic i_bipolar,
	input wire logic i_chan_sel,
	// output register
	input wire logic i_read,
	output logic [ACC_W-1:0] o_data,
	output logic o_new_data,
	output logic o_settled,
	output logic o_overrun,
	// sampling strobes
	output logic o_mod_stb,
	output logic o_samp_stb
);
	localparam int CFG_W = GAIN_W + CODE_W + 2;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [8:0] mdiv;
		logic [8:0] sdiv;
		logic mod_stb;
		logic samp_stb;
		logic [ACC_W-1:0] i1;
		logic [ACC_W-1:0] i2;
		logic [ACC_W-1:0] i3;
		logic [ACC_W-1:0] d1;
		logic [ACC_W-1:0] d2;
		logic [ACC_W-1:0] d3;
		logic [DCNT_W-1:0] dcnt;
		logic [CODE_W-1:0] code;
		logic [CFG_W-1:0] cfg;
		logic [2:0] settle;
		logic [ACC_W-1:0] out_data;
		logic out_settled;
		logic new_data;
		logic overrun;
	} sdf_st_t;

	sdf_st_t st_q, st_d;
	logic [CFG_W-1:0] cfg_now;
	logic dec_now;
	logic [ACC_W-1:0] c1, c2, raw, full;
	logic [ACC_W:0] dbl;
	logic [ACC_W-1:0] coded;

	sdf_stream_if #(.W(ACC_W + 1)) push_if();
	sdf_stream_if #(.W(ACC_W + 1)) pop_if();

	// ------------------------------------------------------------
	// buffer between filter and output register
	// ------------------------------------------------------------
	sdf_fifo #(.W(ACC_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.s_in(push_if.snk),
		.s_out(pop_if.src)
	);

	// ------------------------------------------------------------
	// comb section and output coding
	// ------------------------------------------------------------
	// a change of gain, notch, channel or polarity restarts decimation
	assign cfg_now = {i_gain_sel, clamp_code(i_notch_select_field), i_chan_sel, i_bipolar};
	assign dec_now = st_q.mod_stb && (st_q.cfg == cfg_now)
		&& (CODE_W'(st_q.dcnt) == st_q.code - 1'b1);
	// differentiators at the output rate; sums are exact modulo 2^ACC_W
	assign c1 = st_q.i3 - st_q.d1;
	assign c2 = c1 - st_q.d2;
	assign raw = c2 - st_q.d3;
	assign full = cube(st_q.code);
	assign dbl = {raw, 1'b0} - {1'b0, full};
	// bipolar keeps the offset binary sum, unipolar maps mid-scale to zero
	assign coded = i_bipolar ? raw : (dbl[ACC_W] ? '0 : dbl[ACC_W-1:0]);
	assign push_if.valid = dec_now;
	assign push_if.data = {(st_q.settle == SETTLE_DONE), coded};
	// the output register takes a word when empty or being read
	assign pop_if.ready = !st_q.new_data || i_read;

	// next state
	always_comb begin
		st_d = st_q;
		st_d.sync1 = i_mod_bit;
		st_d.sync2 = st_q.sync1;
		// modulator strobe, independent of gain
		st_d.mod_stb = (st_q.mdiv == '0);
		st_d.mdiv = (st_q.mdiv == '0) ? 9'(MOD_DIV - 1) : st_q.mdiv - 1'b1;
		// input sample strobe, scaled by gain up to eight
		st_d.samp_stb = (st_q.sdiv == '0);
		st_d.sdiv = (st_q.sdiv == '0 || st_q.sdiv >= samp_period(i_gain_sel))
			? samp_period(i_gain_sel) - 1'b1 : st_q.sdiv - 1'b1;
		// integrators at the modulator rate; no nulls at its multiples
		if (st_q.mod_stb) begin
			st_d.i1 = st_q.i1 + ACC_W'(st_q.sync2);
			st_d.i2 = st_q.i2 + st_q.i1;
			st_d.i3 = st_q.i3 + st_q.i2;
			st_d.dcnt = dec_now ? '0 : st_q.dcnt + 1'b1;
		end
		// one decimated word per output period
		if (dec_now) begin
			st_d.d1 = st_q.i3;
			st_d.d2 = c1;
			st_d.d3 = c2;
			if (push_if.ready) begin
				if (st_q.settle != SETTLE_DONE) begin
					st_d.settle = st_q.settle + 1'b1;
				end
			end else begin
				st_d.overrun = 1'b1;
			end
		end
		// a new setting restarts the period and the settling count
		if (st_q.cfg != cfg_now) begin
			st_d.cfg = cfg_now;
			st_d.code = clamp_code(i_notch_select_field);
			st_d.dcnt = '0;
			st_d.settle = '0;
		end
		// output register: load wins over the read that clears it
		if (pop_if.valid && pop_if.ready) begin
			st_d.out_data = pop_if.data[ACC_W-1:0];
			st_d.out_settled = pop_if.data[ACC_W];
			st_d.new_data = 1'b1;
		end else if (i_read) begin
			st_d.new_data = 1'b0;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
			st_q.mdiv <= MDIV_RST;
			st_q.sdiv <= SDIV_RST;
			st_q.code <= CODE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign o_data = st_q.out_data;
	assign o_new_data = st_q.new_data;
	assign o_settled = st_q.out_settled;
	assign o_overrun = st_q.overrun;
	assign o_mod_stb = st_q.mod_stb;
	assign o_samp_stb = st_q.samp_stb;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [9:0] mgap_q;
	logic [9:0] sgap_q;
	logic [GAIN_W-1:0] sgain_q;
	logic sgap_ok_q;
	logic [20:0] dgap_q;
	logic dgap_ok_q;
	// strobe gaps, and gaps between words that follow one another on one setting
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mgap_q <= '0;
			sgap_q <= '0;
			sgain_q <= '0;
			sgap_ok_q <= 1'b0;
			dgap_q <= '0;
			dgap_ok_q <= 1'b0;
		end else begin
			mgap_q <= o_mod_stb ? 10'h001 : mgap_q + 1'b1;
			sgap_q <= o_samp_stb ? 10'h001 : sgap_q + 1'b1;
			sgain_q <= i_gain_sel;
			// the first strobe after a gain change closes a mixed gap
			if (i_gain_sel != sgain_q) begin
				sgap_ok_q <= 1'b0;
			end else if (o_samp_stb) begin
				sgap_ok_q <= 1'b1;
			end
			dgap_q <= push_if.valid ? 21'h000001 : dgap_q + 1'b1;
			// the first word after a setting change closes a gap longer than one period
			if (st_q.cfg != cfg_now) begin
				dgap_ok_q <= 1'b0;
			end else if (push_if.valid) begin
				dgap_ok_q <= 1'b1;
			end
		end
	end

	a_mod_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_mod_stb && $past(o_mod_stb, 2) == 1'b0 && mgap_q != 10'h000 && $past(o_mod_stb) == 1'b0
		&& mgap_q > 10'h001 |-> mgap_q == 10'h200)
		else $error("modulator strobe period is not 512 clocks");

	a_samp_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_samp_stb && $stable(i_gain_sel) && sgap_ok_q && sgap_q > 10'h001
		|-> sgap_q == 10'({1'b0, samp_period(i_gain_sel)}))
		else $error("input sample strobe period does not match gain");

	a_code_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q.code >= CODE_MIN && st_q.code <= CODE_MAX)
		else $error("notch code outside legal span");

	a_dec_point: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		push_if.valid |-> st_q.mod_stb && CODE_W'(st_q.dcnt) == st_q.code - 1'b1
		&& (!dgap_ok_q || dgap_q == {st_q.code, 9'h000}) ##1 st_q.dcnt == '0)
		else $error("output period is not ratio times 512 clocks");

	a_headroom: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		push_if.valid && st_q.settle == SETTLE_DONE |-> raw <= full)
		else $error("settled sum exceeds full scale");

	a_settle_mark: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q.cfg != cfg_now |=> st_q.settle == '0 && !push_if.data[ACC_W])
		else $error("settling count not restarted on setting change");

	a_bipolar_code: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		push_if.valid && i_bipolar |-> push_if.data[ACC_W-1:0] == raw)
		else $error("bipolar word is not offset binary sum");

	a_load_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		pop_if.valid && pop_if.ready |=> o_new_data && o_data == $past(pop_if.data[ACC_W-1:0]))
		else $error("word not loaded in one cycle");

	a_new_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_new_data && !i_read |=> o_new_data && $stable(o_data))
		else $error("new-data dropped before read");
endmodule

// *** testbench/sdf_mod_model.sv ***
// behavioural one-bit modulator feeding the decimation filter
module sdf_mod_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// timing and commanded input level
	input wire logic i_mod_stb,
	input wire logic i_level,
	// bitstream
	output logic o_bit
);
	timeunit 1ns;
	timeprecision 1ns;

	// -----------------------------------------------------------
	// stream generation
	// -----------------------------------------------------------
	// a new bit per modulator cycle; a high level gives a constant full-scale stream,
	// a low level repeats 1,1,1,0 for a three-quarter input
	logic [1:0] phase_q;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bit <= 1'b0;
			phase_q <= '0;
		end else if (i_mod_stb) begin
			phase_q <= phase_q + 1'b1;
			o_bit <= i_level | (phase_q != 2'h3);
		end
	end
endmodule

// *** testbench/sdf_filter_tb.sv ***
// self-checking bench of the sinc3 decimation filter
module sdf_filter_tb
	import sdf_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	// -----------------------------------------------------------
	// compare helper and expectation record
	// -----------------------------------------------------------
	`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
	typedef struct packed {logic s; logic [ACC_W-1:0] d;} sdf_exp_t;
	localparam logic [ACC_W-1:0] FULL = 34'h1acb; // 19 cubed
	localparam logic [ACC_W-1:0] UNI_Q = 34'hfa0; // three-quarter stream at ratio 20, unipolar: 2*6000 - 8000

	// -----------------------------------------------------------
	// signals
	// -----------------------------------------------------------
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic level = 1'b1;
	logic [GAIN_W-1:0] i_gain_sel = 3'h0;
	logic [CODE_W-1:0] i_notch_select_field = 12'h013;
	logic i_bipolar = 1'b1;
	logic i_chan_sel = 1'b0;
	logic i_read = 1'b0;
	logic i_mod_bit, o_new_data, o_settled, o_overrun, o_mod_stb, o_samp_stb;
	logic [ACC_W-1:0] o_data;
	logic [9:0] mcnt = 10'h0;
	logic [9:0] scnt = 10'h0;
	logic [GAIN_W-1:0] gprev = 3'h0;
	logic [7:0] rnd = 8'h29;
	int errors = 0;
	int checks = 0;
	int mskip = 1;
	int sskip = 1;
	sdf_exp_t exp_q[$];
	sdf_exp_t e;

	always #50 i_ref_clk = ~i_ref_clk;

	sdf_filter dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_mod_bit(i_mod_bit), .i_gain_sel(i_gain_sel),
		.i_notch_select_field(i_notch_select_field), .i_bipolar(i_bipolar), .i_chan_sel(i_chan_sel),
		.i_read(i_read), .o_data(o_data), .o_new_data(o_new_data), .o_settled(o_settled),
		.o_overrun(o_overrun), .o_mod_stb(o_mod_stb), .o_samp_stb(o_samp_stb));
	sdf_mod_model modl (.i_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_mod_stb(o_mod_stb), .i_level(level),
		.o_bit(i_mod_bit));

	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// note four words after a change: only the fourth is settled and has its data compared
	task automatic note_words(input logic [ACC_W-1:0] v);
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back('{s: (i == 3), d: v});
		end
	endtask

	// wait, bounded, until every noted word has been seen
	task automatic drain(input string nm);
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 45000) begin
			@(posedge i_ref_clk);
			n++;
		end
		if (exp_q.size() != 0) begin
			errors++;
			$display("CHECK FAILED words expected %0d seen %0d", 4, 4 - exp_q.size());
		end
		`CHK("overrun", 1'b0, o_overrun)
		$display("test %s done", nm);
	endtask

	// -----------------------------------------------------------
	// reader: takes each word and compares it with the oldest note
	// -----------------------------------------------------------
	always @(posedge i_ref_clk) begin
		i_read <= 1'b0;
		if (o_new_data === 1'b1 && i_read === 1'b0) begin
			i_read <= 1'b1;
			if (exp_q.size() == 0) begin
				errors++;
				$display("CHECK FAILED extra_word expected %0d seen %0d", 0, 1);
			end else begin
				e = exp_q.pop_front();
				`CHK("settled", e.s, o_settled)
				if (e.s) `CHK("data", e.d, o_data)
			end
		end
	end

	// -----------------------------------------------------------
	// strobe spacing monitor
	// -----------------------------------------------------------
	always @(posedge i_ref_clk) begin
		mcnt <= mcnt + 10'h1;
		scnt <= scnt + 10'h1;
		gprev <= i_gain_sel;
		if (gprev !== i_gain_sel) sskip = 2;
		if (o_mod_stb === 1'b1) begin
			if (mskip == 0) `CHK("mod_period", 10'h200, mcnt)
			mskip = 0;
			mcnt <= 10'h1;
		end
		if (o_samp_stb === 1'b1) begin
			if (sskip == 0) `CHK("samp_period", 10'(SAMP_DIV >> ((i_gain_sel > 3'h3) ? 3 : i_gain_sel)), scnt)
			if (sskip > 0) sskip--;
			scnt <= 10'h1;
		end
	end

	// -----------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		// every gain code, each long enough for several input samples
		for (int g = 0; g < 8; g++) begin
			@(posedge i_ref_clk);
			i_gain_sel <= 3'(g);
			repeat (1100) @(posedge i_ref_clk);
		end
		$display("test gain_rates done");
		// full-scale positive stream, bipolar coding, notch below range clamps to ratio 19
		rnd = lfsr(rnd);
		@(posedge i_ref_clk);
		i_gain_sel <= 3'h0;
		i_notch_select_field <= 12'(rnd % 8'h13);
		note_words(FULL);
		drain("full_scale_bipolar");
		// step to a three-quarter stream, unipolar coding, random gain, other channel, ratio 20
		rnd = lfsr(rnd);
		@(posedge i_ref_clk);
		level <= 1'b0;
		i_bipolar <= 1'b0;
		i_chan_sel <= 1'b1;
		i_gain_sel <= rnd[2:0];
		i_notch_select_field <= 12'h014;
		note_words(UNI_Q);
		drain("step_unipolar");
		summarize();
	end

	// watchdog sized from the expected run length
	initial begin
		repeat (99000) @(posedge i_ref_clk);
		errors++;
		$display("CHECK FAILED watchdog expected %0d seen %0d", 0, 1);
		summarize();
	end
endmodule
